// ---- stmh_pkg.sv ----
// package: message codes, limits and link layout for the tape target message handler
`default_nettype none
package stmh_pkg;
   localparam int ID_W = 3;
   localparam int N_INIT = 8;
   localparam int CNT_W = 4;
   // message codes
   localparam logic [7:0] MSG_DONE    = 8'h00;
   localparam logic [7:0] MSG_EXT     = 8'h01;
   localparam logic [7:0] MSG_SAVE    = 8'h02;
   localparam logic [7:0] MSG_RESTORE = 8'h03;
   localparam logic [7:0] MSG_DISC    = 8'h04;
   localparam logic [7:0] MSG_IDE     = 8'h05;
   localparam logic [7:0] MSG_ABORT   = 8'h06;
   localparam logic [7:0] MSG_REJECT  = 8'h07;
   localparam logic [7:0] MSG_NOP     = 8'h08;
   localparam logic [7:0] MSG_PARITY  = 8'h09;
   localparam logic [7:0] MSG_BDR     = 8'h0C;
   localparam logic [7:0] MSG_IDENT   = 8'h80;
   // identify fields
   localparam int IDENT_BIT = 7;
   localparam int GRANT_BIT = 6;
   localparam int ROUTINE_BIT = 5;
   localparam int UNIT_HI = 2;
   // synchronous request layout and limits
   localparam logic [7:0] EXT_LEN        = 8'h03;
   localparam logic [7:0] EXT_SDTR       = 8'h01;
   localparam logic [7:0] MIN_PERIOD     = 8'h3E;
   localparam logic [7:0] MAX_OFFSET     = 8'h0C;
   localparam logic [2:0] SDTR_LAST      = 3'h4;
   localparam logic [1:0] EXT_IDX_OFFSET = 2'h3;
   localparam logic [2:0] EXT_BYTES      = 3'h4;
   localparam logic [CNT_W-1:0] CANCEL_LIMIT = 4'h8;
   // sense ending codes
   localparam logic [1:0] SENSE_NONE  = 2'h0;
   localparam logic [1:0] SENSE_ABORT = 2'h1;
   localparam logic [1:0] SENSE_ERROR = 2'h2;
   // initiator controller register offsets
   localparam logic [7:0] OFS_TX   = 8'h00;
   localparam logic [7:0] OFS_CTRL = 8'h04;
   localparam logic [7:0] OFS_STAT = 8'h08;
   localparam logic [7:0] OFS_DPTR = 8'h0C;
   localparam logic [7:0] OFS_SPTR = 8'h10;
   localparam int CTRL_ATN = 0;
   localparam int CTRL_RST = 1;
   localparam int CTRL_SEL = 2;
   localparam int CTRL_ID_LO = 3;
   localparam int STAT_BSY = 8;
   localparam int STAT_SYNC = 9;
   localparam int STAT_PER_LO = 10;
   localparam int STAT_OFS_LO = 18;
   typedef enum logic [2:0] {S_FREE, S_CONN, S_EXT, S_SDTR, S_STAT, S_DONE} stmh_state_t;
endpackage : stmh_pkg
`default_nettype wire

// ---- stmh_link_if.sv ----
// interface: message byte link between target and initiator
`default_nettype none
interface stmh_link_if;
   import stmh_pkg::*;
   logic            sel;
   logic [ID_W-1:0] sel_id;
   logic            atn;
   logic            i_vld;
   logic [7:0]      i_byte;
   logic            bus_rst;
   logic            bsy;
   logic            t_vld;
   logic [7:0]      t_byte;
   modport target (input sel, sel_id, atn, i_vld, i_byte, bus_rst,
                   output bsy, t_vld, t_byte);
   modport initiator (output sel, sel_id, atn, i_vld, i_byte, bus_rst,
                      input bsy, t_vld, t_byte);
endinterface : stmh_link_if
`default_nettype wire

// ---- stmh_target.sv ----
// target end: message decode, synchronous negotiation and connection control
//
// Decided for this implementation: the register offsets and register access over APB.
`default_nettype none
module stmh_target
   import stmh_pkg::*;
(
   input  wire logic             pclk,
   input  wire logic             presetn,
   stmh_link_if.target           lk,
   input  wire logic             cmd_done,
   input  wire logic [7:0]       status_byte,
   input  wire logic             save_req,
   input  wire logic             restore_req,
   input  wire logic             disc_req,
   input  wire logic             fatal_req,
   input  wire logic             resel_req,
   input  wire logic [ID_W-1:0]  resel_id,
   output logic                  cmd_ready,
   output logic [ID_W-1:0]       cur_id,
   output logic                  sync_valid,
   output logic [7:0]            sync_period,
   output logic [7:0]            sync_offset,
   output logic [CNT_W-1:0]      cancel_count,
   output logic                  ptr_unsure,
   output logic [1:0]            sense_code,
   output logic                  clear_pending,
   output logic                  device_reset
);
   stmh_state_t      state_r;
   logic [ID_W-1:0]  id_r;
   logic             grant_r, unit_ok_r, just_neg_r, unsure_r, clr_r, bdr_r;
   logic [1:0]       sense_r;
   logic [1:0]       ext_idx_r;
   logic             ext_ok_r;
   logic [7:0]       ext_per_r, ext_ofs_r, rsp_per_r, rsp_ofs_r;
   logic [2:0]       sdtr_idx_r;
   logic             t_vld_r;
   logic [7:0]       t_byte_r, last_tx_r;
   logic             agr_v_r [N_INIT];
   logic [7:0]       agr_p_r [N_INIT];
   logic [7:0]       agr_o_r [N_INIT];
   logic [CNT_W-1:0] cnt_r   [N_INIT];

   // byte at position idx of the answering synchronous request
   function automatic logic [7:0] sdtr_byte(input logic [2:0] idx,
                                            input logic [7:0] per,
                                            input logic [7:0] ofs);
      unique case (idx)
         3'h0:    sdtr_byte = MSG_EXT;
         3'h1:    sdtr_byte = EXT_LEN;
         3'h2:    sdtr_byte = EXT_SDTR;
         3'h3:    sdtr_byte = per;
         default: sdtr_byte = ofs;
      endcase
   endfunction : sdtr_byte

   // incoming byte decode
   wire logic [7:0] rx       = lk.i_byte;
   wire logic       rx_conn  = lk.i_vld && (state_r == S_CONN);
   wire logic       rx_ident = rx_conn && rx[IDENT_BIT];
   wire logic       ident_unit_ok = !rx[ROUTINE_BIT] && (rx[UNIT_HI:0] == '0);
   wire logic       rx_ext   = rx_conn && !rx[IDENT_BIT] && (rx == MSG_EXT);
   wire logic       rx_ide   = rx_conn && (rx == MSG_IDE);
   wire logic       rx_rej   = rx_conn && (rx == MSG_REJECT);
   wire logic       rx_abort = rx_conn && (rx == MSG_ABORT);
   wire logic       rx_bdr   = rx_conn && (rx == MSG_BDR);
   wire logic       rx_par   = rx_conn && (rx == MSG_PARITY);
   wire logic       rx_nop   = rx_conn && (rx == MSG_NOP);
   // target-to-initiator codes arriving outbound are answered with reject
   wire logic       rx_bad   = rx_conn && !rx[IDENT_BIT] && !rx_ext && !rx_ide && !rx_rej
                               && !rx_abort && !rx_bdr && !rx_par && !rx_nop;
   // cancel only with attention, right after an agreement was made
   wire logic       cancel   = (rx_ide || rx_rej) && lk.atn && just_neg_r;
   wire logic [CNT_W-1:0] cnt_inc = cnt_r[id_r] + 1'b1;
   wire logic       ext_last = lk.i_vld && (state_r == S_EXT) && (ext_idx_r == EXT_IDX_OFFSET);
   wire logic       ext_good = ext_ok_r;
   // answer never faster nor deeper than asked or supported
   wire logic [7:0] ans_per  = (ext_per_r < MIN_PERIOD) ? MIN_PERIOD : ext_per_r;
   wire logic [7:0] ans_ofs  = (rx > MAX_OFFSET) ? MAX_OFFSET : rx;
   wire logic       rst_all  = lk.bus_rst || rx_bdr;

   // per-initiator agreement table and cancel counters
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < N_INIT; i++) begin
            agr_v_r[i] <= 1'b0;
            agr_p_r[i] <= '0;
            agr_o_r[i] <= '0;
            cnt_r[i]   <= '0;
         end
      end else if (rst_all) begin
         for (int i = 0; i < N_INIT; i++) begin
            agr_v_r[i] <= 1'b0;
            cnt_r[i]   <= '0;
         end
      end else if (cancel) begin
         agr_v_r[id_r] <= 1'b0;
         cnt_r[id_r]   <= cnt_inc;
      end else if (state_r == S_SDTR && sdtr_idx_r == SDTR_LAST) begin
         agr_v_r[id_r] <= 1'b1;
         agr_p_r[id_r] <= rsp_per_r;
         agr_o_r[id_r] <= rsp_ofs_r;
      end
   end

   // connection state machine and outgoing bytes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r    <= S_FREE;
         id_r       <= '0;
         grant_r    <= 1'b0;
         unit_ok_r  <= 1'b0;
         just_neg_r <= 1'b0;
         unsure_r   <= 1'b0;
         sense_r    <= SENSE_NONE;
         ext_idx_r  <= '0;
         ext_ok_r   <= 1'b0;
         ext_per_r  <= '0;
         rsp_per_r  <= '0;
         rsp_ofs_r  <= '0;
         sdtr_idx_r <= '0;
         t_vld_r    <= 1'b0;
         t_byte_r   <= '0;
         last_tx_r  <= '0;
         clr_r      <= 1'b0;
         bdr_r      <= 1'b0;
      end else begin
         t_vld_r <= 1'b0;
         clr_r   <= 1'b0;
         bdr_r   <= rx_bdr;
         // any byte after the answer, a cancel too, closes the window
         if (rx_conn) begin
            just_neg_r <= 1'b0;
         end
         if (lk.bus_rst) begin
            state_r <= S_FREE; // reset condition, not a silent free
         end else unique case (state_r)
            S_FREE: begin
               if (lk.sel) begin
                  state_r   <= S_CONN;
                  id_r      <= lk.sel_id;
                  grant_r   <= 1'b0;
                  unit_ok_r <= 1'b0;
                  unsure_r  <= 1'b0;
               end else if (resel_req) begin
                  // reselection re-identifies the path, grant kept
                  state_r   <= S_CONN;
                  id_r      <= resel_id;
                  t_vld_r   <= 1'b1;
                  t_byte_r  <= MSG_IDENT | {1'b0, grant_r, 6'h00};
                  last_tx_r <= MSG_IDENT | {1'b0, grant_r, 6'h00};
               end
            end
            S_CONN: begin
               if (rx_ident) begin
                  grant_r   <= rx[GRANT_BIT];
                  unit_ok_r <= ident_unit_ok;
               end else if (rx_ext) begin
                  state_r   <= S_EXT;
                  ext_idx_r <= '0;
                  ext_ok_r  <= 1'b1;
               end else if (cancel && cnt_inc > CANCEL_LIMIT) begin
                  state_r <= S_FREE;
               end else if (rx_ide) begin
                  unsure_r <= 1'b1;
               end else if (rx_abort) begin
                  clr_r   <= unit_ok_r;
                  sense_r <= SENSE_ABORT;
                  state_r <= S_FREE;
               end else if (rx_bdr) begin
                  state_r <= S_FREE;
               end else if (rx_par) begin
                  t_vld_r  <= 1'b1;
                  t_byte_r <= last_tx_r;
               end else if (rx_bad) begin
                  t_vld_r   <= 1'b1;
                  t_byte_r  <= MSG_REJECT;
                  last_tx_r <= MSG_REJECT;
               end else if (fatal_req) begin
                  sense_r <= SENSE_ERROR;
                  state_r <= S_FREE;
               end else if (cmd_done) begin
                  state_r <= S_STAT;
               end else if (disc_req && grant_r) begin
                  t_vld_r   <= 1'b1;
                  t_byte_r  <= MSG_DISC;
                  last_tx_r <= MSG_DISC;
                  state_r   <= S_FREE;
               end else if (save_req || restore_req) begin
                  t_vld_r   <= 1'b1;
                  t_byte_r  <= save_req ? MSG_SAVE : MSG_RESTORE;
                  last_tx_r <= save_req ? MSG_SAVE : MSG_RESTORE;
               end
            end
            S_EXT: begin
               if (lk.i_vld) begin
                  ext_idx_r <= ext_idx_r + 1'b1;
                  unique case (ext_idx_r)
                     2'h0:    ext_ok_r  <= ext_ok_r && (rx == EXT_LEN);
                     2'h1:    ext_ok_r  <= ext_ok_r && (rx == EXT_SDTR);
                     2'h2:    ext_per_r <= rx;
                     default: ext_ok_r  <= ext_ok_r;
                  endcase
               end
               if (ext_last) begin
                  if (!ext_good) begin
                     state_r   <= S_CONN;
                     t_vld_r   <= 1'b1;
                     t_byte_r  <= MSG_REJECT;
                     last_tx_r <= MSG_REJECT;
                  end else if (cnt_r[id_r] > CANCEL_LIMIT) begin
                     state_r <= S_FREE;
                  end else begin
                     state_r    <= S_SDTR;
                     sdtr_idx_r <= '0;
                     rsp_per_r  <= ans_per;
                     rsp_ofs_r  <= ans_ofs;
                  end
               end
            end
            S_SDTR: begin
               t_vld_r    <= 1'b1;
               t_byte_r   <= sdtr_byte(sdtr_idx_r, rsp_per_r, rsp_ofs_r);
               last_tx_r  <= sdtr_byte(sdtr_idx_r, rsp_per_r, rsp_ofs_r);
               sdtr_idx_r <= sdtr_idx_r + 1'b1;
               if (sdtr_idx_r == SDTR_LAST) begin
                  state_r    <= S_CONN;
                  just_neg_r <= 1'b1;
               end
            end
            S_STAT: begin
               t_vld_r   <= 1'b1;
               t_byte_r  <= status_byte;
               last_tx_r <= status_byte;
               state_r   <= S_DONE;
            end
            S_DONE: begin
               t_vld_r   <= 1'b1;
               t_byte_r  <= MSG_DONE;
               last_tx_r <= MSG_DONE;
               state_r   <= S_FREE;
            end
         endcase
      end
   end

   // busy stays up through the final byte so it precedes the release
   assign lk.bsy        = (state_r != S_FREE) || t_vld_r;
   assign lk.t_vld      = t_vld_r;
   assign lk.t_byte     = t_byte_r;
   assign cmd_ready     = (state_r == S_CONN) && !lk.i_vld;
   assign cur_id        = id_r;
   assign sync_valid    = agr_v_r[id_r];
   assign sync_period   = agr_p_r[id_r];
   assign sync_offset   = agr_o_r[id_r];
   assign cancel_count  = cnt_r[id_r];
   assign ptr_unsure    = unsure_r;
   assign sense_code    = sense_r;
   assign clear_pending = clr_r;
   assign device_reset  = bdr_r;
endmodule : stmh_target
`default_nettype wire

// ---- stmh_initiator.sv ----
// initiator end: apb-controlled message sender with pointer save and restore
`default_nettype none
module stmh_initiator
   import stmh_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   stmh_link_if.initiator   lk,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr
);
   logic             atn_r, rst_r, sel_r, vld_r, sync_r;
   logic [ID_W-1:0]  id_r;
   logic [7:0]       tx_r, rx_r, per_r, ofs_r;
   logic [2:0]       ext_cnt_r;
   logic [31:0]      dptr_r, sptr_r, rdata_r;

   // apb decode, zero wait states
   wire logic acc     = psel && penable;
   wire logic wr      = acc && pwrite;
   wire logic hit_tx  = (paddr == OFS_TX);
   wire logic hit_ctl = (paddr == OFS_CTRL);
   wire logic hit_st  = (paddr == OFS_STAT);
   wire logic hit_dp  = (paddr == OFS_DPTR);
   wire logic hit_sp  = (paddr == OFS_SPTR);
   wire logic mapped  = hit_tx || hit_ctl || hit_st || hit_dp || hit_sp;
   wire logic rx_in   = lk.t_vld;
   wire logic in_ext  = (ext_cnt_r != '0);
   wire logic rx_plain = rx_in && !in_ext;
   wire logic [31:0] ctl_val = {26'h0, id_r, 1'b0, rst_r, atn_r};
   wire logic [31:0] st_val  = {6'h0, ofs_r, per_r, sync_r, lk.bsy, rx_r};

   // register writes and control pulses
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         atn_r <= 1'b0;
         rst_r <= 1'b0;
         sel_r <= 1'b0;
         vld_r <= 1'b0;
         id_r  <= '0;
         tx_r  <= '0;
      end else begin
         sel_r <= wr && hit_ctl && pwdata[CTRL_SEL];
         vld_r <= wr && hit_tx;
         if (wr && hit_tx) begin
            tx_r <= pwdata[7:0];
         end
         if (wr && hit_ctl) begin
            atn_r <= pwdata[CTRL_ATN];
            rst_r <= pwdata[CTRL_RST];
            id_r  <= pwdata[CTRL_ID_LO +: ID_W];
         end
      end
   end

   // incoming messages: pointers and the answered agreement
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_r      <= '0;
         ext_cnt_r <= '0;
         per_r     <= '0;
         ofs_r     <= '0;
         sync_r    <= 1'b0;
         dptr_r    <= '0;
         sptr_r    <= '0;
      end else begin
         if (rst_r) begin
            sync_r <= 1'b0;
         end
         // cancel first, so an answer landing in the same cycle wins
         if (vld_r && atn_r && (tx_r == MSG_IDE || tx_r == MSG_REJECT)) begin
            sync_r <= 1'b0;
         end
         if (wr && hit_dp) begin
            dptr_r <= pwdata;
         end
         if (rx_in) begin
            rx_r <= lk.t_byte;
         end
         if (rx_in && in_ext) begin
            ext_cnt_r <= ext_cnt_r - 1'b1;
            if (ext_cnt_r == 3'h2) begin
               per_r <= lk.t_byte;
            end
            if (ext_cnt_r == 3'h1) begin
               ofs_r  <= lk.t_byte;
               sync_r <= 1'b1;
            end
         end else if (rx_plain && lk.t_byte[IDENT_BIT]) begin
            dptr_r <= sptr_r; // implied restore on reselection
         end else if (rx_plain && lk.t_byte == MSG_EXT) begin
            ext_cnt_r <= EXT_BYTES;
         end else if (rx_plain && lk.t_byte == MSG_SAVE) begin
            sptr_r <= dptr_r;
         end else if (rx_plain && lk.t_byte == MSG_RESTORE) begin
            dptr_r <= sptr_r;
         end
      end
   end

   // read data registered in the setup cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rdata_r <= '0;
      end else if (psel && !penable && !pwrite) begin
         rdata_r <= hit_ctl ? ctl_val :
                    hit_st  ? st_val  :
                    hit_dp  ? dptr_r  :
                    hit_sp  ? sptr_r  : 32'h0000_0000;
      end
   end

   assign prdata     = rdata_r;
   assign pready     = 1'b1;
   assign pslverr    = acc && !mapped;
   assign lk.sel     = sel_r;
   assign lk.sel_id  = id_r;
   assign lk.atn     = atn_r;
   assign lk.i_vld   = vld_r;
   assign lk.i_byte  = tx_r;
   assign lk.bus_rst = rst_r;
endmodule : stmh_initiator
`default_nettype wire

// ---- stmh_link_chk.sv ----
// checker: link-level assertions between the target and initiator ends
`default_nettype none
module stmh_link_chk
   import stmh_pkg::*;
(
   input wire logic            pclk,
   input wire logic            presetn,
   input wire logic            sel,
   input wire logic [ID_W-1:0] sel_id,
   input wire logic            atn,
   input wire logic            i_vld,
   input wire logic [7:0]      i_byte,
   input wire logic            bus_rst,
   input wire logic            bsy,
   input wire logic            t_vld,
   input wire logic [7:0]      t_byte
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic first_r;
   logic grant_r;
   logic [2:0] ext_left_r;
   // grant bit taken from the first byte after a selection
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         first_r <= 1'b0;
         grant_r <= 1'b0;
         ext_left_r <= '0;
      end else begin
         first_r <= sel | (first_r & ~i_vld);
         if (first_r && i_vld) begin
            grant_r <= i_byte[GRANT_BIT];
         end
         // bytes left of an extended message: data, not message codes
         if (i_vld) begin
            ext_left_r <= (ext_left_r != '0) ? ext_left_r - 1'b1 :
                          (i_byte == MSG_EXT) ? EXT_BYTES : 3'h0;
         end
      end
   end
   // a reply starts when no byte went out the cycle before
   sequence s_start(logic [7:0] b);
      t_vld && t_byte == b && !$past(t_vld);
   endsequence
   sequence s_reply_tail;
      t_vld && t_byte == EXT_LEN ##1 t_vld && t_byte == EXT_SDTR
      ##1 t_vld && t_byte >= MIN_PERIOD ##1 t_vld && t_byte <= MAX_OFFSET ##1 !t_vld;
   endsequence
   sdtr_reply_a: assert property (s_start(MSG_EXT) |=> s_reply_tail)
      else $error("synchronous reply malformed or out of limits");
   no_origin_a: assert property (s_start(MSG_EXT) |-> $past(i_vld, 2))
      else $error("target began a synchronous request on its own");
   ident_fields_a: assert property (t_vld && !$past(t_vld) && t_byte[IDENT_BIT]
      |-> t_byte[5:0] == 6'h00)
      else $error("identify sent with nonzero routine or unit");
   done_free_a: assert property (t_vld && t_byte == MSG_DONE && $past(t_vld)
      && !$past(t_vld, 2) |=> !bsy)
      else $error("busy held after completion message");
   disc_free_a: assert property (s_start(MSG_DISC) |=> !bsy)
      else $error("busy held after disconnect message");
   nogrant_disc_a: assert property (s_start(MSG_DISC) |-> grant_r)
      else $error("disconnect sent without grant");
   rst_free_a: assert property (bus_rst |-> ##2 !bsy)
      else $error("busy held through bus reset");
   bdr_free_a: assert property (bsy && i_vld && i_byte == MSG_BDR && ext_left_r == '0
      |-> ##2 !bsy)
      else $error("busy held after device reset message");
   // outside the target's own codes only a status byte may start, then completion
   out_codes_a: assert property (t_vld && !$past(t_vld) && !$past(i_vld)
      && !t_byte[IDENT_BIT] && t_byte > MSG_DISC && t_byte != MSG_REJECT
      |=> t_vld && t_byte == MSG_DONE)
      else $error("target sent a code outside its own set");
endmodule : stmh_link_chk
`default_nettype wire

// ---- tb_scsi_target_message_handler.sv ----
// testbench: both ends joined, apb-driven initiator, target user side driven directly
`default_nettype none
module tb_scsi_target_message_handler
   import stmh_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic             pclk, presetn, psel, penable, pwrite, pready, pslverr, clr_seen, bdr_seen;
   logic             sync_valid, ptr_unsure, clear_pending, device_reset, cmd_ready;
   logic [7:0]       paddr, status_byte, sync_period, sync_offset, ep, eo;
   logic [31:0]      pwdata, prdata, d0;
   logic [5:0]       rq;
   logic [ID_W-1:0]  resel_id, cur_id;
   logic [CNT_W-1:0] cancel_count;
   logic [1:0]       sense_code;
   logic [7:0]       tq[$];
   logic [31:0]      rdq[$];
   int               failures, samples_checked;
   stmh_link_if lk();
   stmh_target stmh_target_inst (.pclk(pclk), .presetn(presetn), .lk(lk), .cmd_done(rq[0]),
      .status_byte(status_byte), .save_req(rq[1]), .restore_req(rq[2]), .disc_req(rq[3]),
      .fatal_req(rq[4]), .resel_req(rq[5]), .resel_id(resel_id), .cmd_ready(cmd_ready),
      .cur_id(cur_id), .sync_valid(sync_valid), .sync_period(sync_period),
      .sync_offset(sync_offset), .cancel_count(cancel_count), .ptr_unsure(ptr_unsure),
      .sense_code(sense_code), .clear_pending(clear_pending), .device_reset(device_reset));
   stmh_initiator stmh_initiator_inst (.pclk(pclk), .presetn(presetn), .lk(lk), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr));
   stmh_link_chk stmh_link_chk_inst (.pclk(pclk), .presetn(presetn), .sel(lk.sel),
      .sel_id(lk.sel_id), .atn(lk.atn), .i_vld(lk.i_vld), .i_byte(lk.i_byte),
      .bus_rst(lk.bus_rst), .bsy(lk.bsy), .t_vld(lk.t_vld), .t_byte(lk.t_byte));
   // free-running core clock
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : give_verdict
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   // apb master: holds the request until pready is seen high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic e);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      check("slave error", 32'(pslverr), 32'(e));
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic err);
      rdq.push_back(e);
      apb(1'b0, a, 32'h0, err);
   endtask : rd
   task automatic tx(input logic [7:0] b);
      apb(1'b1, OFS_TX, {24'h0, b}, 1'b0);
   endtask : tx
   task automatic ctl(input logic [2:0] bits);
      apb(1'b1, OFS_CTRL, {26'h0, 3'h3, bits}, 1'b0);
   endtask : ctl
   task automatic fire(input int i);
      @(posedge pclk);
      rq[i] <= 1'b1;
      @(posedge pclk);
      rq <= 6'h00;
   endtask : fire
   // wait for every noted target byte to appear, bounded
   task automatic drain();
      int n = 0;
      while (tq.size() != 0 && n < 100) begin
         @(posedge pclk);
         n++;
      end
      check("pending bytes", 32'(tq.size()), 32'h0);
      repeat (3) @(posedge pclk);
   endtask : drain
   // random request: reply clamps period up and offset down
   task automatic sdtr();
      logic [7:0] p;
      logic [7:0] o;
      p = 8'($urandom_range(96, 16));
      o = 8'($urandom_range(20, 1));
      ep = (p < MIN_PERIOD) ? MIN_PERIOD : p;
      eo = (o > MAX_OFFSET) ? MAX_OFFSET : o;
      tq = '{MSG_EXT, EXT_LEN, EXT_SDTR, ep, eo};
      foreach (tq[i]) tx(i == 3 ? p : (i == 4 ? o : tq[i]));
      drain();
      check("agreed", 32'(sync_valid), 32'h1);
      check("period", 32'(sync_period), 32'(ep));
      check("offset", 32'(sync_offset), 32'(eo));
      rd(OFS_STAT, {6'h0, eo, ep, 2'h3, eo}, 1'b0);
   endtask : sdtr
   // compares each target byte and each read with the oldest note
   always @(posedge pclk) begin
      clr_seen <= presetn && (clr_seen || clear_pending === 1'b1);
      bdr_seen <= presetn && (bdr_seen || device_reset === 1'b1);
      if (lk.t_vld === 1'b1)
         check("target byte", {24'h0, lk.t_byte},
               (tq.size() > 0) ? {24'h0, tq.pop_front()} : 32'hFFFF_FFFF);
      if ((psel & penable & pready & ~pwrite) === 1'b1 && rdq.size() > 0)
         check("read data", prdata, rdq.pop_front());
   end
   // watchdog cuts a hang short
   initial begin
      repeat (5000) @(posedge pclk);
      failures++;
      give_verdict();
   end
   initial begin
      {psel, penable, pwrite, paddr, pwdata, rq, status_byte} = '0;
      resel_id = 3'h3;
      presetn = 1'b0;
      void'($urandom(68283));
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      ctl(3'b101);
      tx(8'hC0);
      drain();
      check("current id", 32'(cur_id), 32'h3);
      d0 = $urandom;
      apb(1'b1, OFS_DPTR, d0, 1'b0);
      rd(8'h14, 32'h0, 1'b1);
      // nine abnormal cancels, alternating error and reject
      for (int k = 1; k <= 9; k++) begin
         sdtr();
         tx(k[0] ? MSG_IDE : MSG_REJECT);
         repeat (3) @(posedge pclk);
         if (k == 1) check("unsure", 32'(ptr_unsure), 32'h1);
         if (k < 9) check("cancels", 32'(cancel_count), 32'(k));
         if (k < 9) check("cancelled", 32'(sync_valid), 32'h0);
         else check("limit free", 32'(lk.bsy), 32'h0);
      end
      ctl(3'b011);
      ctl(3'b001);
      check("cancels reset", 32'(cancel_count), 32'h0);
      check("agreement reset", 32'(sync_valid), 32'h0);
      ctl(3'b101);
      tx(8'hC0);
      drain();
      sdtr();
      tq.push_back(MSG_SAVE);
      fire(1);
      drain();
      rd(OFS_SPTR, d0, 1'b0);
      apb(1'b1, OFS_DPTR, ~d0, 1'b0);
      tq.push_back(MSG_RESTORE);
      fire(2);
      drain();
      rd(OFS_DPTR, d0, 1'b0);
      tq.push_back(MSG_DISC);
      fire(3);
      drain();
      check("disconnect free", 32'(lk.bsy), 32'h0);
      tq.push_back(8'hC0);
      fire(5);
      drain();
      check("reselected", 32'(lk.bsy), 32'h1);
      check("ready", 32'(cmd_ready), 32'h1);
      status_byte <= 8'h18;
      tq = '{8'h18, MSG_DONE};
      fire(0);
      drain();
      check("complete free", 32'(lk.bsy), 32'h0);
      check("agreement kept", 32'(sync_valid), 32'h1);
      ctl(3'b101);
      tx(MSG_IDENT);
      fire(3);
      repeat (4) @(posedge pclk);
      check("no grant held", 32'(lk.bsy), 32'h1);
      tx(MSG_ABORT);
      repeat (3) @(posedge pclk);
      check("abort free", 32'(lk.bsy), 32'h0);
      check("abort sense", 32'(sense_code), 32'(SENSE_ABORT));
      check("abort clear", 32'(clr_seen), 32'h1);
      ctl(3'b101);
      tx(MSG_IDENT);
      fire(4);
      repeat (3) @(posedge pclk);
      check("fatal free", 32'(lk.bsy), 32'h0);
      check("error sense", 32'(sense_code), 32'(SENSE_ERROR));
      ctl(3'b101);
      tx(MSG_IDENT);
      tq = '{MSG_REJECT, MSG_REJECT};
      tx(8'h0A);
      tx(MSG_PARITY);
      tx(MSG_NOP);
      drain();
      tx(MSG_BDR);
      repeat (3) @(posedge pclk);
      check("reset free", 32'(lk.bsy), 32'h0);
      check("reset agreement", 32'(sync_valid), 32'h0);
      check("device reset", 32'(bdr_seen), 32'h1);
      give_verdict();
   end
endmodule : tb_scsi_target_message_handler
`default_nettype wire
